// [reset_source_control.sv]
`timescale 1ns/1ps
module reset_source_control (
	// Clock and power-on reset
	input wire logic clock,
	input wire logic rst,
	// External reset pin and power-down request
	input wire logic reset_pin,
	input wire logic power_down_req,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core view
	output logic core_reset,
	output logic [15:0] program_counter,
	output logic [7:0] stack_pointer,
	output logic [7:0] port_latch,
	output logic watchdog_irq,
	output logic clock_stopped
);
	import reset_pkg::*;

	typedef enum {st_run, st_reset, st_stretch} rst_state_e;
	rst_state_e state;
	logic pin_meta, pin_sync, pin_sample;
	logic [1:0] clk_state;
	logic [1:0] stretch_cnt;
	logic [1:0] divider;
	logic pd_active;
	logic por_ind, wdt_ind, to_flag, wdt_en, wdt_int_en;
	logic [1:0] interval;
	logic [17:0] wdt_count;
	logic [9:0] grace_cnt;
	logic grace_run;
	logic wdt_fire;
	logic restart_wr;
	logic wr_en, rd_en;
	logic [31:0] next_rdata;
	logic any_reset;
	ram_bus_if ram_bus();

	function automatic logic [17:0] interval_limit(input logic [1:0] sel);
		case (sel)
			2'h0: interval_limit = 18'h01FFF;
			2'h1: interval_limit = 18'h07FFF;
			2'h2: interval_limit = 18'h0FFFF;
			default: interval_limit = 18'h3FFFF;
		endcase
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// Write lands only at the edge that completes the transfer
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite && !pready;
	assign restart_wr = wr_en && hit(paddr, addr_wdt_restart);
	assign any_reset = rst || state != st_run;

	// Two-flop synchroniser; first stage feeds only the second
	always_ff @(posedge clock) begin
		pin_meta <= reset_pin;
		pin_sync <= pin_meta;
	end

	// Clock state counter, four clocks per machine cycle; runs through the stretch so it can end
	always_ff @(posedge clock) begin
		if (rst || state == st_reset) begin
			clk_state <= 2'h0;
		end else begin
			clk_state <= clk_state + 2'h1;
		end
	end

	// Sample the pin at the fourth clock state while running; every clock in reset, stretch or power-down
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_sample <= 1'b0;
		end else if (clk_state == fourth_clock_state || state != st_run || pd_active) begin
			pin_sample <= pin_sync; // Power-down has no cycle, so track directly
		end
	end

	// Reset sequencer, synchronous to the core clock
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= st_reset;
			stretch_cnt <= 2'h0;
		end else begin
			case (state)
				st_run: begin
					if (pin_sample || wdt_fire) begin
						state <= st_reset;
					end
				end
				st_reset: begin
					if (!pin_sample) begin
						state <= st_stretch;
						stretch_cnt <= 2'h0;
					end
				end
				st_stretch: begin
					// Count machine cycles: four clocks each
					if (pin_sample) begin
						state <= st_reset;
					end else if (stretch_cnt == 2'(stretch_cycles - 1) && clk_state == fourth_clock_state) begin
						state <= st_run;
					end else if (clk_state == fourth_clock_state) begin
						stretch_cnt <= stretch_cnt + 2'h1;
					end
				end
				default: state <= st_reset;
			endcase
		end
	end

	// Power-down: ended by pin high
	always_ff @(posedge clock) begin
		if (rst) begin
			pd_active <= 1'b0;
		end else if (pin_sample) begin
			pd_active <= 1'b0;
		end else if (power_down_req && state == st_run) begin
			pd_active <= 1'b1;
		end
	end

	// Core register reset values
	always_ff @(posedge clock) begin
		if (any_reset) begin
			program_counter <= pc_reset;
			stack_pointer <= sp_reset;
			port_latch <= port_reset;
			divider <= divider_default;
		end else if (!pd_active && !core_reset) begin
			program_counter <= program_counter + 16'h0001; // First cycle out of reset shows 0000h
		end
	end

	// Reset-cause flags and enables
	always_ff @(posedge clock) begin
		if (rst) begin
			por_ind <= 1'b1;
			wdt_ind <= 1'b0;
			wdt_en <= 1'b0;
			wdt_int_en <= 1'b0;
			to_flag <= 1'b0;
			interval <= interval_reset;
		end else if (wdt_fire) begin
			wdt_ind <= 1'b1; // Set by watchdog reset or by a control-register write
			to_flag <= 1'b0;
			wdt_int_en <= 1'b0;
		end else if (pin_sample && state == st_run) begin
			to_flag <= 1'b0; // External reset sets no cause flag
			wdt_int_en <= 1'b0;
		end else begin
			if (wr_en && hit(paddr, addr_wdt_ctrl)) begin
				por_ind <= pwdata[bit_por];
				wdt_ind <= pwdata[bit_wdt_reset_ind];
				wdt_en <= pwdata[bit_wdt_reset_en];
			end
			if (wr_en && hit(paddr, addr_int_enable)) begin
				wdt_int_en <= pwdata[bit_wdt_int_en];
			end
			if (wr_en && hit(paddr, addr_wdt_interval)) begin
				interval <= pwdata[1:0];
			end
			// Hardware set wins over a same-cycle software clear
			if (wdt_count == interval_limit(interval) && !restart_wr) begin
				to_flag <= 1'b1;
			end else if (wr_en && hit(paddr, addr_wdt_ctrl)) begin
				to_flag <= pwdata[bit_timeout_flag];
			end
		end
	end

	// Free-running watchdog counter, restart on write
	always_ff @(posedge clock) begin
		if (any_reset || restart_wr || wdt_count == interval_limit(interval)) begin
			wdt_count <= 18'h0;
		end else if (!pd_active) begin
			wdt_count <= wdt_count + 18'h1;
		end
	end

	// Grace window after timeout before the reset
	always_ff @(posedge clock) begin
		if (any_reset || restart_wr) begin
			grace_run <= 1'b0;
			grace_cnt <= 10'h0;
		end else if (wdt_count == interval_limit(interval) && wdt_en && !grace_run) begin
			grace_run <= 1'b1;
			grace_cnt <= 10'h0;
		end else if (grace_run && !pd_active) begin
			grace_cnt <= grace_cnt + 10'h1; // Stopped clock: no watchdog reset in power-down
		end
	end
	assign wdt_fire = grace_run && grace_cnt == 10'(wdt_grace_clocks - 1) && state == st_run;

	// Interrupt output gated by enable bit
	always_ff @(posedge clock) begin
		if (rst) begin
			watchdog_irq <= 1'b0;
			core_reset <= 1'b1;
			clock_stopped <= 1'b0;
		end else begin
			watchdog_irq <= to_flag && wdt_int_en;
			core_reset <= state != st_run;
			clock_stopped <= pd_active;
		end
	end

	// RAM access port, unaffected by reset
	assign ram_bus.we = wr_en && paddr[7:6] == addr_ram_base[7:6];
	assign ram_bus.addr = paddr[5:2];
	assign ram_bus.wdata = pwdata[7:0];
	scratch_ram u_ram (
		.clock(clock),
		.bus(ram_bus)
	);

	// Read mux
	always_comb begin
		next_rdata = 32'h0;
		if (paddr[7:6] == addr_ram_base[7:6]) begin
			next_rdata = {24'h0, ram_bus.rdata};
		end else if (hit(paddr, addr_wdt_ctrl)) begin
			next_rdata[bit_por] = por_ind;
			next_rdata[bit_timeout_flag] = to_flag;
			next_rdata[bit_wdt_reset_ind] = wdt_ind;
			next_rdata[bit_wdt_reset_en] = wdt_en;
		end else if (hit(paddr, addr_wdt_interval)) begin
			next_rdata = {30'h0, interval};
		end else if (hit(paddr, addr_int_enable)) begin
			next_rdata[bit_wdt_int_en] = wdt_int_en;
		end else if (hit(paddr, addr_core_status)) begin
			next_rdata = {28'h0, divider, pd_active, state != st_run};
		end else if (hit(paddr, addr_sfr_view)) begin
			next_rdata = {16'h0, port_latch, stack_pointer};
		end
	end

	// APB answer: one wait state, so registered RAM data matches the address
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			if (rd_en) begin
				prdata <= next_rdata;
			end
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && paddr[1:0] != 2'h0;
		end
	end

	// Reset is held through two full machine cycles after the pin drops
	property p_stretch;
		@(posedge clock) disable iff (rst) $fell(pin_sample) && state == st_reset |-> core_reset [*8];
	endproperty
	a_stretch: assert property (p_stretch) else $error("reset released early");

	property p_pc;
		@(posedge clock) disable iff (rst) state != st_run |=> program_counter == 16'h0000;
	endproperty
	a_pc: assert property (p_pc) else $error("pc not held at zero");

	property p_sp;
		@(posedge clock) disable iff (rst) state != st_run |=> stack_pointer == 8'h07 && port_latch == 8'hFF;
	endproperty
	a_sp: assert property (p_sp) else $error("sp or port not reset");

	property p_irq;
		@(posedge clock) disable iff (rst) watchdog_irq |-> $past(wdt_int_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without enable");

	property p_fire;
		@(posedge clock) disable iff (rst) wdt_fire |=> wdt_ind && state == st_reset;
	endproperty
	a_fire: assert property (p_fire) else $error("watchdog reset not taken");

	property p_div;
		@(posedge clock) disable iff (rst) state == st_reset |=> divider == 2'h1;
	endproperty
	a_div: assert property (p_div) else $error("divider not default");

	property p_sample;
		@(posedge clock) disable iff (rst) state == st_run && !pd_active && clk_state != 2'h3 |=> $stable(pin_sample);
	endproperty
	a_sample: assert property (p_sample) else $error("pin sampled off c4");

	property p_ext;
		@(posedge clock) disable iff (rst) state == st_run && pin_sample && !wdt_fire |=> $stable(wdt_ind);
	endproperty
	a_ext: assert property (p_ext) else $error("external reset set a flag");
endmodule

// [reset_pkg.sv]
package reset_pkg;
	// Register byte addresses on the APB
	localparam logic [7:0] addr_wdt_ctrl = 8'h00;
	localparam logic [7:0] addr_wdt_interval = 8'h04;
	localparam logic [7:0] addr_wdt_restart = 8'h08;
	localparam logic [7:0] addr_int_enable = 8'h0C;
	localparam logic [7:0] addr_core_status = 8'h10;
	localparam logic [7:0] addr_sfr_view = 8'h14;
	localparam logic [7:0] addr_ram_base = 8'h40;
	// Control and interrupt-enable register bit positions
	localparam int bit_por = 6;
	localparam int bit_timeout_flag = 3;
	localparam int bit_wdt_reset_ind = 2;
	localparam int bit_wdt_reset_en = 1;
	localparam int bit_wdt_int_en = 4;
	// Reset values
	localparam logic [7:0] sp_reset = 8'h07;
	localparam logic [7:0] port_reset = 8'hFF;
	localparam logic [15:0] pc_reset = 16'h0000;
	localparam logic [1:0] divider_default = 2'h1;
	// Machine cycle timing, watchdog settings and RAM size
	localparam int clocks_per_cycle = 4;
	localparam logic [1:0] fourth_clock_state = 2'h3;
	localparam int stretch_cycles = 2;
	localparam int wdt_grace_clocks = 512;
	localparam logic [1:0] interval_reset = 2'h0;
	localparam int ram_words = 16;
	localparam int ram_aw = 4;
endpackage

// [ram_bus_if.sv]
`timescale 1ns/1ps
interface ram_bus_if;
	logic we;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport master (output we, output addr, output wdata, input rdata);
	modport slave (input we, input addr, input wdata, output rdata);
endinterface

// [scratch_ram.sv]
`timescale 1ns/1ps
module scratch_ram (
	// Clock only: no reset, contents survive every reset
	input wire logic clock,
	// Access port
	ram_bus_if.slave bus
);
	import reset_pkg::*;
	logic [7:0] mem [ram_words];

	// Write port, never touched by reset
	always_ff @(posedge clock) begin
		if (bus.we) begin
			mem[bus.addr] <= bus.wdata;
		end
	end

	// Registered read data
	always_ff @(posedge clock) begin
		bus.rdata <= mem[bus.addr];
	end
endmodule

// [reset_pin_driver.sv]
`timescale 1ns/1ps
// Stand-in for the board's reset circuit
module reset_pin_driver (
	// Clock and trigger
	input wire logic clock,
	input wire logic rst,
	input wire logic go,
	input wire logic [7:0] clocks_high,
	// Pin
	output logic reset_pin
);
	logic [7:0] left;
	// Pin stays high for the asked clocks, then falls back to pull-down
	always_ff @(posedge clock) begin
		if (rst) begin
			left <= 8'h00;
		end else if (go) begin
			left <= clocks_high;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end
	assign reset_pin = (left != 8'h00);
endmodule

// [reset_source_control_bench.sv]
`timescale 1ns/1ps
module reset_source_control_bench;
	import reset_pkg::*;
	logic clock, rst, reset_pin, power_down_req, psel, penable, pwrite, pready, pslverr;
	logic core_reset, watchdog_irq, clock_stopped, go;
	logic [7:0] paddr, stack_pointer, port_latch, plen;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] program_counter;
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	reset_source_control u_dut (.clock(clock), .rst(rst), .reset_pin(reset_pin),
		.power_down_req(power_down_req), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_reset(core_reset), .program_counter(program_counter), .stack_pointer(stack_pointer),
		.port_latch(port_latch), .watchdog_irq(watchdog_irq), .clock_stopped(clock_stopped));
	reset_pin_driver u_pin (.clock(clock), .rst(rst), .go(go), .clocks_high(plen), .reset_pin(reset_pin));
	// Free-running core clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic summarize;
		if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; no fixed latency assumed, bounded wait on pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		chk("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? core_reset : (s == 1 ? watchdog_irq : clock_stopped);
	endfunction
	// Bounded wait for a level on one design output
	task automatic wait_for(input int s, input logic v, input int lim);
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk("wait_ok", 32'h1, {31'h0, n < lim});
	endtask
	task automatic pin_pulse;
		@(posedge clock);
		go <= 1'b1;
		plen <= 8'h08;
		@(posedge clock);
		go <= 1'b0;
	endtask
	initial begin
		rst <= 1'b1;
		power_down_req <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		go <= 1'b0;
		plen <= 8'h00;
		repeat (16) @(posedge clock);
		chk("pc", 32'h0, {16'h0, program_counter});
		chk("sp", 32'h07, {24'h0, stack_pointer});
		chk("port", 32'hFF, {24'h0, port_latch});
		rst <= 1'b0;
		apb(1'b0, addr_wdt_ctrl, 32'h0);
		chk("ctrl_por", 32'h40, r);
		wait_for(0, 1'b0, 40);
		apb(1'b1, addr_wdt_ctrl, 32'h02);
		// Kicks well inside the 8192-clock limit keep the flag clear
		repeat (3) begin
			repeat (6000) @(posedge clock);
			apb(1'b1, addr_wdt_restart, 32'h0);
		end
		apb(1'b0, addr_wdt_ctrl, 32'h0);
		chk("no_timeout", 32'h02, r & 32'h0E);
		apb(1'b1, addr_int_enable, 32'h10);
		apb(1'b1, addr_ram_base + 8'h04, 32'hA5);
		pin_pulse();
		wait_for(0, 1'b1, 20);
		chk("pc_ext", 32'h0, {16'h0, program_counter});
		chk("sp_ext", 32'h07, {24'h0, stack_pointer});
		wait_for(0, 1'b0, 40);
		apb(1'b0, addr_wdt_ctrl, 32'h0);
		chk("ctrl_ext", 32'h02, r & 32'h06);
		apb(1'b0, addr_int_enable, 32'h0);
		chk("ie_ext", 32'h0, r);
		apb(1'b0, addr_ram_base + 8'h04, 32'h0);
		chk("ram_first", 32'hA5, r);
		apb(1'b0, addr_ram_base + 8'h04, 32'h0);
		chk("ram_kept", 32'hA5, r);
		apb(1'b1, addr_int_enable, 32'h10);
		wait_for(1, 1'b1, 9000);
		wait_for(0, 1'b1, 600);
		chk("grace", 32'h1, {31'h0, n >= 505 && n <= 520});
		wait_for(0, 1'b0, 40);
		chk("held", 32'h1, {31'h0, n >= 8});
		chk("pc_wdt", 32'h0, {16'h0, program_counter});
		apb(1'b0, addr_wdt_ctrl, 32'h0);
		chk("ctrl_wdt", 32'h06, r & 32'h46);
		apb(1'b0, addr_core_status, 32'h0);
		chk("divider", 32'h4, r & 32'h0C);
		apb(1'b0, 8'h01, 32'h0);
		chk("misaligned", 32'h1, {31'h0, pslverr});
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped", 32'h0, r);
		apb(1'b1, addr_wdt_interval, 32'h3);
		apb(1'b0, addr_wdt_interval, 32'h0);
		chk("interval", 32'h3, r);
		power_down_req <= 1'b1;
		wait_for(2, 1'b1, 20);
		power_down_req <= 1'b0;
		pin_pulse();
		wait_for(2, 1'b0, 40);
		wait_for(0, 1'b0, 40);
		chk("pc_wake", 32'h0, {16'h0, program_counter});
		summarize();
	end
	// Hang guard well beyond the expected run
	initial begin
		#(8 * 60000);
		mismatches++;
		summarize();
	end
endmodule
